// ==== pkg/vsa_map.vh ====
// constants for the video input select and gain loop block
// assumes it is included by bare name from the decoder and top design files of the block
//
// Functional notes
// - four-bit selection field picks active sources
// - codes 0-2 luma pins, 4-6 chroma pins composite
// - codes 8,9,A pair matching luma and chroma pins
// - code F: luma two, chroma one, chroma two
// - two paths, own gain, clamp, 8-bit converter
// - composite uses luma path only
// - s-video and component use both paths
// - corrections computed from samples, fed back
// - loop regulates sync tip to porch difference
// - level bit clear: tip 2, porch 70
// - level bit set: tip 16, porch 70
// - overflow bit: lower gain on maximum code
// - hold bit freezes gain, stops tracking
// - while held, gain follows written manual value
// - two-bit field selects tracking time constant
// - speed-up bit doubles tracking rate while acquiring
`ifndef VSA_MAP_VH
`define VSA_MAP_VH

// ************************************************************
// selection codes
// ************************************************************
`define VSA_SEL_Y0 4'h0
`define VSA_SEL_Y1 4'h1
`define VSA_SEL_Y2 4'h2
`define VSA_SEL_C0 4'h4
`define VSA_SEL_C1 4'h5
`define VSA_SEL_C2 4'h6
`define VSA_SEL_SV0 4'h8
`define VSA_SEL_SV1 4'h9
`define VSA_SEL_SV2 4'hA
`define VSA_SEL_COMP 4'hF

// ************************************************************
// analog pin indices driven to the input multiplexers
// ************************************************************
`define VSA_PIN_Y0 3'h0
`define VSA_PIN_Y1 3'h1
`define VSA_PIN_Y2 3'h2
`define VSA_PIN_C0 3'h3
`define VSA_PIN_C1 3'h4
`define VSA_PIN_C2 3'h5

// ************************************************************
// converter code targets
// ************************************************************
`define VSA_TIP_LOW 8'h02
`define VSA_TIP_HIGH 8'h10
`define VSA_PORCH 8'h46
`define VSA_CHROMA_PORCH 8'h80
`define VSA_CODE_MAX 8'hFF

// ************************************************************
// loop reset values and tuning
// ************************************************************
`define VSA_GAIN_RST 16'h8000
`define VSA_CLAMP_RST 8'h80
`define VSA_TC_BASE 3'h4
`define VSA_OVF_STEP 19'h00100
`define VSA_LOCK_TOL 10'h004
`define VSA_LOCK_LINES 4'hF
`define VSA_GAIN_MAX 19'h0FFFF

`endif

// ==== logic/vsa_sync2.v ====
// two-flop synchroniser for static or slow pins from outside the clock domain
// assumes the pins change rarely; each bit is synchronised on its own
`timescale 1ns/1ps
module vsa_sync2 #(
  parameter WIDTH = 1
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] sync_o
);

  // first stage, read only by the second stage
  reg [WIDTH-1:0] meta_r;
  // second stage, safe for logic
  reg [WIDTH-1:0] stable_r;

  // ************************************************************
  // two flip-flops in series
  // ************************************************************
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_r <= {WIDTH{1'b0}};
      stable_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= pin_i;
      stable_r <= meta_r;
    end
  end

  assign sync_o = stable_r;

endmodule

// ==== logic/vsa_route_dec.v ====
// combinational decoder from the source selection field to mux settings
// assumes the caller registers the outputs before they leave the block
`timescale 1ns/1ps
`include "vsa_map.vh"
module vsa_route_dec (
  input wire [3:0] source_select_field_i,
  output reg [2:0] luma_sel_o,
  output reg [2:0] chroma_sel_o,
  output reg [2:0] red_diff_sel_o,
  output reg luma_en_o,
  output reg chroma_en_o,
  output reg component_o,
  output reg valid_o
);

  // ************************************************************
  // decode the selection code
  // ************************************************************
  always @*
  begin
    // defaults: valid code, both paths idle
    luma_sel_o = `VSA_PIN_Y0;
    chroma_sel_o = `VSA_PIN_C0;
    red_diff_sel_o = `VSA_PIN_C0;
    luma_en_o = 1'b0;
    chroma_en_o = 1'b0;
    component_o = 1'b0;
    valid_o = 1'b1;
    case (source_select_field_i)
      // composite on luma pins, luma path only
      `VSA_SEL_Y0: begin luma_sel_o = `VSA_PIN_Y0; luma_en_o = 1'b1; end
      `VSA_SEL_Y1: begin luma_sel_o = `VSA_PIN_Y1; luma_en_o = 1'b1; end
      `VSA_SEL_Y2: begin luma_sel_o = `VSA_PIN_Y2; luma_en_o = 1'b1; end
      // composite on chroma pins, still through the luma path
      `VSA_SEL_C0: begin luma_sel_o = `VSA_PIN_C0; luma_en_o = 1'b1; end
      `VSA_SEL_C1: begin luma_sel_o = `VSA_PIN_C1; luma_en_o = 1'b1; end
      `VSA_SEL_C2: begin luma_sel_o = `VSA_PIN_C2; luma_en_o = 1'b1; end
      // s-video pairs with matching index
      `VSA_SEL_SV0:
      begin
        luma_sel_o = `VSA_PIN_Y0;
        chroma_sel_o = `VSA_PIN_C0;
        luma_en_o = 1'b1;
        chroma_en_o = 1'b1;
      end
      `VSA_SEL_SV1:
      begin
        luma_sel_o = `VSA_PIN_Y1;
        chroma_sel_o = `VSA_PIN_C1;
        luma_en_o = 1'b1;
        chroma_en_o = 1'b1;
      end
      `VSA_SEL_SV2:
      begin
        luma_sel_o = `VSA_PIN_Y2;
        chroma_sel_o = `VSA_PIN_C2;
        luma_en_o = 1'b1;
        chroma_en_o = 1'b1;
      end
      // three-wire component: chroma path carries both differences
      `VSA_SEL_COMP:
      begin
        luma_sel_o = `VSA_PIN_Y2;
        chroma_sel_o = `VSA_PIN_C1;
        red_diff_sel_o = `VSA_PIN_C2;
        luma_en_o = 1'b1;
        chroma_en_o = 1'b1;
        component_o = 1'b1;
      end
      // reserved codes park both paths
      default: valid_o = 1'b0;
    endcase
  end

endmodule

// ==== logic/vsa_top.v ====
// input selection and digital gain loop for the analog front end
// assumes converter codes and line strobes come from logic on clock_i;
// test and identifier pins are static board straps and are synchronised
`timescale 1ns/1ps
`include "vsa_map.vh"
module vsa_top (
  input wire clock_i,
  input wire arst_n_i,
  // selection and loop control bits
  input wire [3:0] source_select_field_i,
  input wire gain_level_set_i,
  input wire overflow_gain_reduce_i,
  input wire gain_hold_i,
  input wire [1:0] gain_loop_time_const_i,
  input wire acquisition_speedup_i,
  input wire [7:0] manual_gain_i,
  // digitised samples from both converters
  input wire [7:0] luma_code_i,
  input wire [7:0] chroma_code_i,
  // line timing from the sync separator
  input wire sync_tip_strobe_i,
  input wire back_porch_strobe_i,
  input wire line_end_i,
  // board straps
  input wire test_mode_pin_a_i,
  input wire test_mode_pin_b_i,
  input wire [1:0] serial_id_select_pins_i,
  // multiplexer settings
  output reg [2:0] luma_sel_o,
  output reg [2:0] chroma_sel_o,
  output reg [2:0] red_diff_sel_o,
  output reg luma_en_o,
  output reg chroma_en_o,
  output reg component_o,
  output reg route_valid_o,
  // analog corrections
  output wire [7:0] luma_gain_o,
  output wire [7:0] luma_clamp_o,
  output wire [7:0] chroma_gain_o,
  output wire [7:0] chroma_clamp_o,
  // loop status
  output wire luma_locked_o,
  output wire chroma_locked_o,
  // straps seen by the rest of the chip
  output reg test_mode_o,
  output reg [1:0] serial_id_o
);

  // ************************************************************
  // strap synchronisers
  // ************************************************************

  // synchronised test pins
  wire [1:0] test_sync;
  // synchronised identifier pins
  wire [1:0] id_sync;

  vsa_sync2 #(
    .WIDTH(4)
  ) u_strap_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .pin_i({test_mode_pin_b_i, test_mode_pin_a_i, serial_id_select_pins_i}),
    .sync_o({test_sync, id_sync})
  );

  // either pin high means test mode; the identifier is only passed on
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      test_mode_o <= 1'b0;
      serial_id_o <= 2'h0;
    end
    else
    begin
      test_mode_o <= test_sync[0] | test_sync[1];
      serial_id_o <= id_sync;
    end
  end

  // ************************************************************
  // source routing
  // ************************************************************

  // decoder results before registering
  wire [2:0] dec_luma_sel;
  wire [2:0] dec_chroma_sel;
  wire [2:0] dec_red_sel;
  wire dec_luma_en;
  wire dec_chroma_en;
  wire dec_component;
  wire dec_valid;

  vsa_route_dec u_route (
    .source_select_field_i(source_select_field_i),
    .luma_sel_o(dec_luma_sel),
    .chroma_sel_o(dec_chroma_sel),
    .red_diff_sel_o(dec_red_sel),
    .luma_en_o(dec_luma_en),
    .chroma_en_o(dec_chroma_en),
    .component_o(dec_component),
    .valid_o(dec_valid)
  );

  // register the mux settings so the analog switches see clean levels
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // reset lands on the first composite input
      luma_sel_o <= `VSA_PIN_Y0;
      chroma_sel_o <= `VSA_PIN_C0;
      red_diff_sel_o <= `VSA_PIN_C0;
      luma_en_o <= 1'b1;
      chroma_en_o <= 1'b0;
      component_o <= 1'b0;
      route_valid_o <= 1'b1;
    end
    else
    begin
      luma_sel_o <= dec_luma_sel;
      chroma_sel_o <= dec_chroma_sel;
      red_diff_sel_o <= dec_red_sel;
      luma_en_o <= dec_luma_en;
      chroma_en_o <= dec_chroma_en;
      component_o <= dec_component;
      route_valid_o <= dec_valid;
    end
  end

  // ************************************************************
  // shared loop settings
  // ************************************************************

  // sync tip target picked by the level bit
  wire [7:0] tip_target = gain_level_set_i ? `VSA_TIP_HIGH : `VSA_TIP_LOW;
  // wanted tip to porch distance, 68 or 54 codes
  wire [9:0] diff_target = {2'h0, `VSA_PORCH} - {2'h0, tip_target};

  // ************************************************************
  // two independent paths: 0 = luma, 1 = chroma
  // ************************************************************
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_path
      // sample of this path's converter
      wire [7:0] code = (p == 0) ? luma_code_i : chroma_code_i;
      // path carries signal for the current selection
      wire active = (p == 0) ? luma_en_o : chroma_en_o;
      // chroma has no sync tip, so only luma tracks the difference
      wire track = (p == 0);
      // clamp target: porch code for luma, mid-scale for chroma
      wire [7:0] clamp_target = (p == 0) ? `VSA_PORCH : `VSA_CHROMA_PORCH;

      // per-line measurement
      reg [7:0] tip_r;
      reg [7:0] porch_r;
      reg tip_seen_r;
      reg porch_seen_r;
      reg ovf_seen_r;
      // gain, integer in the upper byte, fraction below
      reg [15:0] acc_r;
      reg [15:0] acc_nxt;
      // clamp offset code
      reg [7:0] clamp_r;
      reg [7:0] clamp_nxt;
      // acquisition state
      reg [3:0] lock_cnt_r;
      reg locked_r;

      // measured distance and its error, signed
      wire [9:0] meas = {2'h0, porch_r} - {2'h0, tip_r};
      wire [9:0] err = diff_target - meas;
      wire [9:0] err_abs = err[9] ? (~err + 10'h001) : err;
      // a full line with both levels sampled
      wire measured = tip_seen_r & porch_seen_r;
      // shift sets the time constant; one less halves it
      wire [2:0] shift_base = `VSA_TC_BASE + {1'b0, gain_loop_time_const_i};
      wire [2:0] shift = (acquisition_speedup_i & ~locked_r) ?
                         (shift_base - 3'h1) : shift_base;
      // error scaled into gain units
      wire signed [18:0] delta = $signed({err, 8'h00, 1'b0}) >>> ({1'b0, shift} + 4'h1);
      // sum with headroom for saturation
      wire signed [18:0] sum = $signed({3'h0, acc_r}) + delta;
      // overflow backs gain off by one integer step
      wire signed [18:0] ovf_sum = $signed({3'h0, acc_r}) - $signed(`VSA_OVF_STEP);

      // next gain and clamp, computed every cycle, loaded only at line end
      always @*
      begin
        acc_nxt = acc_r;
        clamp_nxt = clamp_r;
        if (gain_hold_i)
        begin
          // frozen: software owns the gain
          acc_nxt = {manual_gain_i, 8'h00};
        end
        else if (active)
        begin
          if (overflow_gain_reduce_i && ovf_seen_r)
          begin
            // limiting beats normal tracking
            acc_nxt = ovf_sum[18] ? 16'h0000 : ovf_sum[15:0];
          end
          else if (track && measured)
          begin
            if (sum[18])
              acc_nxt = 16'h0000;
            else if (sum > $signed(`VSA_GAIN_MAX))
              acc_nxt = 16'hFFFF;
            else
              acc_nxt = sum[15:0];
          end
        end
        // clamp still tracks while the gain is frozen
        if (active && porch_seen_r)
        begin
          if (porch_r < clamp_target && clamp_r != 8'hFF)
            clamp_nxt = clamp_r + 8'h01;
          else if (porch_r > clamp_target && clamp_r != 8'h00)
            clamp_nxt = clamp_r - 8'h01;
        end
      end

      // measurement capture and once-per-line update
      always @(posedge clock_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          tip_r <= 8'h00;
          porch_r <= 8'h00;
          tip_seen_r <= 1'b0;
          porch_seen_r <= 1'b0;
          ovf_seen_r <= 1'b0;
          acc_r <= `VSA_GAIN_RST;
          clamp_r <= `VSA_CLAMP_RST;
          lock_cnt_r <= 4'h0;
          locked_r <= 1'b0;
        end
        else if (line_end_i)
        begin
          // apply corrections, then start a fresh line
          acc_r <= acc_nxt;
          clamp_r <= clamp_nxt;
          tip_seen_r <= 1'b0;
          porch_seen_r <= 1'b0;
          ovf_seen_r <= 1'b0;
          // lock after a run of small errors; chroma locks on any run of measured lines
          if (!active || gain_hold_i)
          begin
            lock_cnt_r <= 4'h0;
            locked_r <= 1'b0;
          end
          else if (measured && (!track || err_abs <= `VSA_LOCK_TOL))
          begin
            if (lock_cnt_r == `VSA_LOCK_LINES)
              locked_r <= 1'b1;
            else
              lock_cnt_r <= lock_cnt_r + 4'h1;
          end
          else if (measured)
          begin
            lock_cnt_r <= 4'h0;
            locked_r <= 1'b0;
          end
        end
        else
        begin
          // sample the two reference levels of this line
          if (sync_tip_strobe_i)
          begin
            tip_r <= code;
            tip_seen_r <= 1'b1;
          end
          if (back_porch_strobe_i)
          begin
            porch_r <= code;
            porch_seen_r <= 1'b1;
          end
          // any full-scale sample in the line counts as limiting
          if (code == `VSA_CODE_MAX)
            ovf_seen_r <= 1'b1;
        end
      end
    end
  endgenerate

  // ************************************************************
  // corrections out to the analog stages
  // ************************************************************
  assign luma_gain_o = g_path[0].acc_r[15:8];
  assign luma_clamp_o = g_path[0].clamp_r;
  assign chroma_gain_o = g_path[1].acc_r[15:8];
  assign chroma_clamp_o = g_path[1].clamp_r;
  assign luma_locked_o = g_path[0].locked_r;
  assign chroma_locked_o = g_path[1].locked_r;

endmodule

// ==== verification/vsa_top_asserts.sv ====
// checker for the input select and gain loop block, bound to its top
// assumes it sees top-level ports only, all on clock_i
`timescale 1ns/1ps
module vsa_top_asserts (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [3:0] source_select_field_i,
  input wire logic gain_hold_i,
  input wire logic line_end_i,
  input wire logic [7:0] manual_gain_i,
  input wire logic test_mode_pin_a_i,
  input wire logic test_mode_pin_b_i,
  input wire logic [2:0] luma_sel_o,
  input wire logic [2:0] chroma_sel_o,
  input wire logic [2:0] red_diff_sel_o,
  input wire logic luma_en_o,
  input wire logic chroma_en_o,
  input wire logic component_o,
  input wire logic route_valid_o,
  input wire logic [7:0] luma_gain_o,
  input wire logic [7:0] chroma_gain_o,
  input wire logic luma_locked_o,
  input wire logic chroma_locked_o,
  input wire logic test_mode_o
);
  // ****
  // helpers
  // ****
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  wire [3:0] fld = source_select_field_i; // current code
  wire rsv = fld == 4'h3 || fld == 4'h7 || (fld > 4'hA && fld < 4'hF); // unlisted codes
  // a held line end overrides both tracking and overflow reduction
  sequence s_hold_line;
    gain_hold_i && line_end_i;
  endsequence
  // straps must stay up through both sync flops and the output flop
  sequence s_strap_high;
    (test_mode_pin_a_i || test_mode_pin_b_i) [*3];
  endsequence
  // ****
  // properties
  // ****
  a_reserved_route: assert property (rsv |=> !route_valid_o && !luma_en_o && !chroma_en_o)
    else $error("reserved code left a path enabled");
  a_composite_luma: assert property (fld < 4'h7 && !rsv |=> luma_en_o && !chroma_en_o)
    else $error("composite code did not use luma path alone");
  a_dual_path: assert property (fld > 4'h7 && !rsv |=> luma_en_o && chroma_en_o)
    else $error("two-path code left a path idle");
  a_composite_pins: assert property (fld < 4'h7 && !rsv |=>
    luma_sel_o == $past(fld[2:0]) - {2'b00, $past(fld[2])})
    else $error("composite pin index wrong");
  a_svideo_pins: assert property (fld > 4'h7 && fld < 4'hB |=>
    luma_sel_o == $past(fld[2:0]) && chroma_sel_o == $past(fld[2:0]) + 3'h3)
    else $error("pair pin indices wrong");
  a_component_pins: assert property (fld == 4'hF |=> luma_sel_o == 3'h2 &&
    chroma_sel_o == 3'h4 && red_diff_sel_o == 3'h5 && component_o)
    else $error("component pins wrong");
  a_gain_line_only: assert property (!line_end_i |=>
    $stable(luma_gain_o) && $stable(chroma_gain_o))
    else $error("gain moved outside a line end");
  a_hold_manual: assert property (s_hold_line |=> luma_gain_o == $past(manual_gain_i) &&
    chroma_gain_o == $past(manual_gain_i))
    else $error("held gain does not follow manual value");
  a_hold_unlocked: assert property (s_hold_line |=> !luma_locked_o && !chroma_locked_o)
    else $error("held loop still reports lock");
  a_strap_test: assert property (s_strap_high |=> test_mode_o)
    else $error("test strap not seen after three edges");
endmodule
bind vsa_top vsa_top_asserts chk_u (.*);

// ==== verification/vsa_video_src.sv ====
// far-side video source: line timing and converter codes for the gain loop
// assumes one clock with the block; a line is 16 samples while run_i is high
`timescale 1ns/1ps
module vsa_video_src (
  input wire clock_i,
  input wire arst_n_i,
  input wire run_i,
  input wire [7:0] tip_code_i,
  input wire [7:0] porch_code_i,
  output wire [7:0] luma_code_o,
  output wire [7:0] chroma_code_o,
  output wire sync_tip_strobe_o,
  output wire back_porch_strobe_o,
  output wire line_end_o,
  output reg [7:0] line_cnt_o
);
  reg [3:0] pos_r; // sample position within the line
  // ****
  // line position
  // ****
  // restart when stopped so each run begins with a whole line
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pos_r <= 4'h0;
      line_cnt_o <= 8'h00;
    end
    else
    begin
      pos_r <= run_i ? pos_r + 4'h1 : 4'h0;
      line_cnt_o <= run_i ? line_cnt_o + {7'h00, line_end_o} : 8'h00;
    end
  end
  // one tip and one porch per line, then the line end
  assign sync_tip_strobe_o = run_i && pos_r == 4'h2;
  assign back_porch_strobe_o = run_i && pos_r == 4'h6;
  assign line_end_o = run_i && pos_r == 4'hF;
  // a bright peak mid-line drives the converter to full scale
  assign luma_code_o = sync_tip_strobe_o ? tip_code_i : back_porch_strobe_o ? porch_code_i :
    (run_i && pos_r == 4'hA) ? 8'hFF : 8'h40;
  assign chroma_code_o = luma_code_o;
endmodule

// ==== verification/vsa_top_tb_top.sv ====
// testbench for the input select and gain loop block
// assumes the checker binds itself; the source model supplies line timing
`timescale 1ns/1ps
module vsa_top_tb_top;
  reg clock_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg [3:0] source_select_field_i = 4'h0;
  reg gain_level_set_i = 1'b0, overflow_gain_reduce_i = 1'b0, gain_hold_i = 1'b0;
  reg acquisition_speedup_i = 1'b0, test_mode_pin_a_i = 1'b0, test_mode_pin_b_i = 1'b1;
  reg [1:0] gain_loop_time_const_i = 2'h0, serial_id_select_pins_i = 2'h2;
  reg [7:0] manual_gain_i = 8'h5A, tip = 8'h02, porch = 8'h46;
  reg run = 1'b0;
  wire [7:0] luma_code_i, chroma_code_i, luma_gain_o, luma_clamp_o;
  wire [7:0] chroma_gain_o, chroma_clamp_o, line_cnt;
  wire sync_tip_strobe_i, back_porch_strobe_i, line_end_i;
  wire [2:0] luma_sel_o, chroma_sel_o, red_diff_sel_o;
  wire luma_en_o, chroma_en_o, component_o, route_valid_o;
  wire luma_locked_o, chroma_locked_o, test_mode_o;
  wire [1:0] serial_id_o;
  wire [15:0] route_now = {route_valid_o, component_o, luma_en_o, chroma_en_o,
    1'b0, luma_sel_o, 1'b0, chroma_sel_o, 1'b0, red_diff_sel_o};
  // code, overflow, level, time constant, speed-up, hold
  localparam [99:0] cfg_tab = {10'h000, 10'h050, 10'h094, 10'h118, 10'h15C,
    10'h19E, 10'h020, 10'h220, 10'h251, 10'h0F0};
  integer err_total = 0, compares = 0, i, n, acc;
  reg [9:0] w;
  reg [7:0] eg;
  vsa_video_src src_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .run_i(run), .tip_code_i(tip),
    .porch_code_i(porch), .luma_code_o(luma_code_i), .chroma_code_o(chroma_code_i),
    .sync_tip_strobe_o(sync_tip_strobe_i), .back_porch_strobe_o(back_porch_strobe_i),
    .line_end_o(line_end_i), .line_cnt_o(line_cnt)
  );
  vsa_top dut_u (.*);
  // ****
  // clock, tasks, expectation
  // ****
  initial
  begin
    forever #20 clock_i = ~clock_i;
  end
  // inputs move 1 ns after the edge so sampling never races
  task tick;
  begin
    @(posedge clock_i);
    #1;
  end
  endtask
  task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task do_reset;
  begin
    arst_n_i = 1'b0;
    repeat (12) tick;
    arst_n_i = 1'b1;
  end
  endtask
  // wait for k finished lines; running out of time counts as a mismatch
  task run_lines(input [7:0] k);
  begin
    n = 0;
    while (line_cnt !== k && n < 300)
    begin
      tick;
      n = n + 1;
    end
    if (line_cnt !== k)
    begin
      err_total = err_total + 1;
      $display("mismatch line_cnt expected %h seen %h", k, line_cnt);
    end
  end
  endtask
  // packed valid, component, luma on, chroma on, luma pin, chroma pin, red pin
  function [15:0] rexp(input [3:0] c);
  begin
    rexp = {4'hA, 12'h033};
    if (c < 4'h3)
      rexp[10:8] = c[2:0];
    else if (c > 4'h3 && c < 4'h7)
      rexp[10:8] = c[2:0] - 3'h1;
    else if (c > 4'h7 && c < 4'hB)
      rexp = {4'hB, 1'b0, c[2:0], 1'b0, c[2:0] + 3'h3, 4'h3};
    else if (c == 4'hF)
      rexp = {4'hF, 12'h245};
    else
      rexp = 16'h0033;
  end
  endfunction
  task report_and_stop;
  begin
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    repeat (12) tick;
    chk("route_rst", rexp(4'h0), route_now);
    chk("gains_rst", 16'h8080, {luma_gain_o, chroma_gain_o});
    chk("clamps_rst", 16'h8080, {luma_clamp_o, chroma_clamp_o});
    chk("straps_rst", 16'h0000, {11'h000, luma_locked_o, chroma_locked_o, test_mode_o,
      serial_id_o});
    arst_n_i = 1'b1;
    repeat (3) tick;
    chk("straps", 16'h0006, {13'h0000, test_mode_o, serial_id_o});
    // hand test mode over to the other pin alone
    {test_mode_pin_a_i, test_mode_pin_b_i} = 2'b10;
    $display("test reset and straps done");
    // every code back to back, one cycle apart
    for (i = 0; i < 16; i = i + 1)
    begin
      source_select_field_i = i[3:0];
      tick;
      chk("route", rexp(i[3:0]), route_now);
    end
    chk("straps_a", 16'h0006, {13'h0000, test_mode_o, serial_id_o});
    // back to normal straps with a new identifier
    {test_mode_pin_a_i, serial_id_select_pins_i} = 3'h1;
    $display("test routing done");
    // ten lines per setting, loop restarted from reset each time
    for (i = 0; i < 10; i = i + 1)
    begin
      w = cfg_tab[(9 - i) * 10 +: 10];
      {source_select_field_i, overflow_gain_reduce_i, gain_level_set_i,
        gain_loop_time_const_i, acquisition_speedup_i, gain_hold_i} = w;
      tip = w[4] ? 8'h10 : 8'h02;
      porch = tip + 8'h44;
      do_reset;
      run = 1'b1;
      run_lines(8'h0A);
      run = 1'b0;
      acc = 32768 - (w[4] ? 10 * (3584 >> (4 + w[3:2] - w[1])) : 0);
      eg = w[0] ? 8'h5A : (w[9:6] == 4'h3) ? 8'h80 : w[5] ? 8'h76 : acc[15:8];
      chk("luma_gain", {8'h00, eg}, {8'h00, luma_gain_o});
      eg = w[0] ? 8'h5A : (w[9] && w[5]) ? 8'h76 : 8'h80;
      chk("chroma_gain", {8'h00, eg}, {8'h00, chroma_gain_o});
      eg = (w[4] && w[9:6] != 4'h3) ? 8'h76 : 8'h80;
      chk("luma_clamp", {8'h00, eg}, {8'h00, luma_clamp_o});
      eg = w[9] ? 8'h8A : 8'h80;
      chk("chroma_clamp", {8'h00, eg}, {8'h00, chroma_clamp_o});
    end
    $display("test gain loop done");
    // a clean pair input locks both paths on the sixteenth good line, not before
    source_select_field_i = 4'h8;
    overflow_gain_reduce_i = 1'b0;
    gain_level_set_i = 1'b0;
    gain_hold_i = 1'b0;
    tip = 8'h02;
    porch = 8'h46;
    do_reset;
    run = 1'b1;
    run_lines(8'h0F);
    chk("locks_15", 16'h0000, {14'h0000, luma_locked_o, chroma_locked_o});
    run_lines(8'h10);
    chk("locks_16", 16'h0003, {14'h0000, luma_locked_o, chroma_locked_o});
    run = 1'b0;
    chk("straps_end", 16'h0001, {13'h0000, test_mode_o, serial_id_o});
    $display("test lock and straps done");
    report_and_stop;
  end
  // watchdog well beyond the expected run of about 2000 cycles
  initial
  begin
    #400000;
    err_total = err_total + 1;
    report_and_stop;
  end
endmodule
